// ### dv/tb_core_instruction_subset_exec.sv
// self-checking bench for the instruction subset execution block
// assumes results land one edge after the word is taken
`timescale 1ns/1ps
`include "core_exec_map.svh"
module tb_core_instruction_subset_exec;
   logic                    ref_clk;
   logic                    nrst;
   logic                    instr_valid;
   logic [13:0]             instr;
   logic [7:0]              file_rd_data;
   logic [7:0]              latch;
   logic [7:0]              acc_reg;
   logic [6:0]              file_rd_addr;
   logic [14:0]             pc_reg;
   core_exec_pkg::file_wr_t file_wr;
   core_exec_pkg::push_t    stack_push;
   logic                    zero_flag_reg;
   logic                    wd_exp_n;
   logic                    sleep_n;
   logic                    wd_clr;
   logic                    ps_clr;
   logic                    busy;
   logic                    retire;
   logic [7:0]              fmem [128];
   int                      mismatches;
   int                      total_checks;
   int                      e_pc;
   int                      e_acc;
   int                      e_z;
   // file reads are combinational, other entries differ so a wrong address shows
   assign file_rd_data = fmem[file_rd_addr];
   core_instruction_subset_exec u_dut (
      .ref_clk(ref_clk), .nrst(nrst), .instr(instr), .instr_valid(instr_valid),
      .file_rd_data(file_rd_data), .file_rd_addr(file_rd_addr),
      .program_counter_upper_latch(latch), .file_wr(file_wr), .stack_head_push(stack_push),
      .pc_reg(pc_reg), .acc_reg(acc_reg), .zero_flag_reg(zero_flag_reg),
      .watchdog_expiry_flag_n(wd_exp_n), .sleep_entry_flag_n(sleep_n),
      .watchdog_counter_clr(wd_clr), .watchdog_prescaler_clr(ps_clr),
      .busy(busy), .retire(retire));
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge ref_clk);
      nrst <= 1'b0;
      instr_valid <= 1'b0;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      chk_val({11'h000, busy, wd_exp_n, sleep_n, retire, file_wr.en}, 16'h001c);
      chk_val({1'b0, pc_reg}, 16'h0000);
      @(posedge ref_clk);
      nrst <= 1'b1;
      e_pc = 0;
      e_acc = 0;
      e_z = 0;
   endtask
   // skip-taken, jump and call leave a dead cycle; hold keeps a clear-acc word
   // pending into it so a refusal failure shows up as a changed accumulator
   task automatic step(input logic [13:0] w, input logic [7:0] fv, input bit hold);
      logic [7:0] r;
      logic [7:0] lv;
      logic [6:0] a;
      bit         two, wr, dst, zu, kick, call;
      int         ret;
      a = w[6:0];
      lv = 8'($urandom);
      r = fv;
      ret = (e_pc + 1) & 32'h7fff;
      {two, wr, dst, zu, kick, call} = 6'h00;
      if (w == `OP_ISC) {call, two} = 2'h3;
      else if (w == `OP_ZACC) {e_acc, e_z} = {32'h0, 32'h1};
      else if (w == `OP_WDK) kick = 1;
      else if (w[13:11] == `OP3_JUMP) two = 1;
      else if (w[13:7] == `OP7_ZREG) {r, wr, e_z} = {`ZERO_BYTE, 1'b1, 32'h1};
      else if (w[13:8] == `OP6_COMP) {r, dst, zu} = {~fv, 2'h3};
      else if (w[13:8] == `OP6_DEC) {r, dst, zu} = {fv - `ONE_BYTE, 2'h3};
      else if (w[13:8] == `OP6_DSZ) {r, dst, two} = {fv - `ONE_BYTE, 1'b1, fv == `ONE_BYTE};
      if (dst && w[`DEST_BIT]) wr = 1;
      else if (dst) e_acc = r;
      if (zu) e_z = (r == 8'h00);
      if (call) e_pc = {lv[6:0], 8'(e_acc)};
      else if (two && !dst) e_pc = {lv[6:3], w[10:0]};
      else e_pc = ret;
      @(posedge ref_clk);
      instr <= w;
      instr_valid <= 1'b1;
      latch <= lv;
      fmem[a] <= fv;
      @(posedge ref_clk);
      instr <= `OP_ZACC;
      instr_valid <= hold & two;
      @(negedge ref_clk);
      chk_val({1'b0, pc_reg}, 16'(e_pc));
      chk_val({8'h00, acc_reg}, 16'(e_acc));
      chk_bit(zero_flag_reg, e_z[0]);
      chk_val({14'h0000, busy, retire}, {14'h0000, two, 1'b1});
      chk_bit(file_wr.en, wr);
      if (wr) chk_val({1'b0, file_wr.addr, file_wr.data}, {1'b0, a, r});
      chk_bit(stack_push.en, call);
      if (call) chk_val({1'b0, stack_push.ret_addr}, 16'(ret));
      chk_val({14'h0000, wd_clr, ps_clr}, {14'h0000, kick, kick});
      chk_val({14'h0000, wd_exp_n, sleep_n}, 16'h0003);
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      if (two) e_pc = (e_pc + 1) & 32'h7fff;
      @(negedge ref_clk);
      chk_val({1'b0, pc_reg}, 16'(e_pc));
      chk_val({7'h00, zero_flag_reg, acc_reg}, 16'((e_z << 8) | e_acc));
      chk_val({11'h000, busy, retire, file_wr.en, stack_push.en, wd_clr}, 16'h0000);
   endtask
   logic [13:0] dw [14] = '{{`OP6_COMP, 8'h00}, {`OP6_COMP, 8'hff}, `OP_ISC,
      {`OP6_DEC, 8'h11}, {`OP6_DEC, 8'ha2}, `OP_ZACC, {`OP6_COMP, 8'h05},
      {`OP6_DSZ, 8'hb3}, {`OP6_DSZ, 8'h44}, {`OP7_ZREG, 7'h7f}, `OP_WDK,
      {`OP3_JUMP, 11'h7ff}, {`OP3_JUMP, 11'h000}, 14'h0000};
   logic [7:0]  dv [14] = '{8'h5a, 8'hff, 8'h00, 8'h01, 8'h00, 8'h77, 8'h3c,
      8'h01, 8'h02, 8'h99, 8'h00, 8'h00, 8'h00, 8'h00};
   initial begin
      int          k;
      logic [13:0] rw;
      logic [7:0]  rv;
      ref_clk = 1'b0;
      nrst = 1'b0;
      instr = 14'h0000;
      instr_valid = 1'b0;
      latch = 8'h00;
      mismatches = 0;
      total_checks = 0;
      void'($urandom(48939));
      foreach (fmem[i]) fmem[i] = 8'($urandom);
      for (int p = 0; p < 2; p++) begin
         do_reset();
         if (p == 0) begin
            for (int i = 0; i < 14; i++) step(dw[i], dv[i], 1'b1);
            $display("test directed done");
         end
         for (int i = 0; i < 300; i++) begin
            k = $urandom % 32'h9;
            rw = 14'($urandom);
            case (k)
               0: rw = `OP_ISC;
               1: rw = `OP_ZACC;
               2: rw = `OP_WDK;
               3: rw[13:8] = `OP6_COMP;
               4: rw[13:8] = `OP6_DEC;
               5: rw[13:8] = `OP6_DSZ;
               6: rw[13:7] = `OP7_ZREG;
               7: rw[13:11] = `OP3_JUMP;
               default: rw = 14'h0000;
            endcase
            rv = 8'($urandom);
            if (rv[7:6] == 2'h0) rv = `ONE_BYTE;
            step(rw, rv, 1'($urandom));
         end
         $display("test random pass %0d done", p);
      end
      final_report();
   end
   initial begin
      repeat (32'h0000_4e20) @(posedge ref_clk);
      mismatches++;
      final_report();
   end
endmodule // tb_core_instruction_subset_exec

// ### rtl/core_instruction_subset_exec.sv
// execution of call-through-accumulator, complement, clears, decrements,
// watchdog kick and absolute jump; one instruction per ref_clk cycle, two for jump, call and taken skip.
// assumes file read data arrives combinationally for the current word.
`timescale 1ns/1ps
`include "core_exec_map.svh"
module core_instruction_subset_exec (
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    nrst,
   // instruction fetch
   input  wire logic [13:0]             instr,
   input  wire logic                    instr_valid,
   // file register read port
   input  wire logic [7:0]              file_rd_data,
   output logic      [6:0]              file_rd_addr,
   // upper address latch
   input  wire logic [7:0]              program_counter_upper_latch,
   // writes and stack
   output core_exec_pkg::file_wr_t      file_wr,
   output core_exec_pkg::push_t         stack_head_push,
   // architectural state
   output logic      [14:0]             pc_reg,
   output logic      [7:0]              acc_reg,
   output logic                         zero_flag_reg,
   output logic                         watchdog_expiry_flag_n,
   output logic                         sleep_entry_flag_n,
   // watchdog clears
   output logic                         watchdog_counter_clr,
   output logic                         watchdog_prescaler_clr,
   // pipeline
   output logic                         busy,
   output logic                         retire
);
   core_exec_pkg::op_t    op;
   core_exec_pkg::state_t state_reg;
   core_exec_pkg::state_t state_next;
   logic                  is_jump;
   logic                  dest_file;
   logic [7:0]            result;
   logic                  exec_now;
   logic                  take_skip;
   logic                  flow_change;

   op_decode u_dec (
      .instr   (instr),
      .op      (op),
      .is_jump (is_jump)
   );

   assign exec_now     = instr_valid && (state_reg == core_exec_pkg::ST_EXEC);
   assign file_rd_addr = instr[6:0];
   assign dest_file    = instr[`DEST_BIT];
   assign busy         = (state_reg != core_exec_pkg::ST_EXEC);

   always_comb begin
      unique case (op)
         core_exec_pkg::OP_COMP: result = ~file_rd_data;
         core_exec_pkg::OP_DEC,
         core_exec_pkg::OP_DSZ:  result = file_rd_data - `ONE_BYTE;
         default:                result = `ZERO_BYTE;
      endcase
   end

   assign take_skip   = exec_now && (op == core_exec_pkg::OP_DSZ) &&
                        (result == `ZERO_BYTE);
   assign flow_change = exec_now && (is_jump || op == core_exec_pkg::OP_ISC);

   // two-cycle ops spend their second cycle discarding the fetched word
   always_comb begin
      state_next = core_exec_pkg::ST_EXEC;
      unique case (state_reg)
         core_exec_pkg::ST_EXEC:
            if (take_skip || flow_change) begin
               state_next = core_exec_pkg::ST_FLUSH;
            end
         core_exec_pkg::ST_FLUSH:  state_next = core_exec_pkg::ST_EXEC;
         core_exec_pkg::ST_SETTLE: state_next = core_exec_pkg::ST_EXEC;
         default:                  state_next = core_exec_pkg::ST_EXEC;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= core_exec_pkg::ST_SETTLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // program counter
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc_reg <= `PC_RESET;
      end else if (exec_now && op == core_exec_pkg::OP_ISC) begin
         pc_reg <= {program_counter_upper_latch[6:0], acc_reg};
      end else if (exec_now && is_jump) begin
         pc_reg <= {program_counter_upper_latch[6:3], instr[10:0]};
      end else if (exec_now || state_reg == core_exec_pkg::ST_FLUSH) begin
         pc_reg <= pc_reg + 15'h0001;
      end
   end

   // return address push
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stack_head_push <= '0;
      end else begin
         stack_head_push.en       <= exec_now && op == core_exec_pkg::OP_ISC;
         stack_head_push.ret_addr <= pc_reg + 15'h0001;
      end
   end

   // accumulator
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         acc_reg <= `ACC_RESET;
      end else if (exec_now) begin
         unique case (op)
            core_exec_pkg::OP_ZACC: acc_reg <= `ZERO_BYTE;
            core_exec_pkg::OP_COMP,
            core_exec_pkg::OP_DEC,
            core_exec_pkg::OP_DSZ:
               if (!dest_file) begin
                  acc_reg <= result;
               end
            default: acc_reg <= acc_reg;
         endcase
      end
   end

   // file register write back
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         file_wr <= '0;
      end else begin
         file_wr.addr <= instr[6:0];
         file_wr.data <= result;
         file_wr.en   <= exec_now && ((op == core_exec_pkg::OP_ZREG) ||
                         (dest_file && (op == core_exec_pkg::OP_COMP ||
                          op == core_exec_pkg::OP_DEC ||
                          op == core_exec_pkg::OP_DSZ)));
      end
   end

   // zero flag; skip, jump and call leave it alone
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         zero_flag_reg <= `ZERO_FLAG_RESET;
      end else if (exec_now) begin
         unique case (op)
            core_exec_pkg::OP_ZREG,
            core_exec_pkg::OP_ZACC: zero_flag_reg <= 1'b1;
            core_exec_pkg::OP_COMP,
            core_exec_pkg::OP_DEC:  zero_flag_reg <= (result == `ZERO_BYTE);
            default:                zero_flag_reg <= zero_flag_reg;
         endcase
      end
   end

   // watchdog side effects and retire strobe; status bits only ever raised here
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         watchdog_counter_clr   <= 1'b0;
         watchdog_prescaler_clr <= 1'b0;
         watchdog_expiry_flag_n <= `STATUS_N_RESET;
         sleep_entry_flag_n     <= `STATUS_N_RESET;
         retire                 <= 1'b0;
      end else begin
         watchdog_counter_clr   <= exec_now && op == core_exec_pkg::OP_WDK;
         watchdog_prescaler_clr <= exec_now && op == core_exec_pkg::OP_WDK;
         if (exec_now && op == core_exec_pkg::OP_WDK) begin
            watchdog_expiry_flag_n <= 1'b1;
            sleep_entry_flag_n     <= 1'b1;
         end
         retire <= exec_now;
      end
   end

   a_call_pc_load: assert property (@(posedge ref_clk) disable iff (!nrst)
      exec_now && op == core_exec_pkg::OP_ISC |=>
      pc_reg == {$past(program_counter_upper_latch[6:0]), $past(acc_reg)})
      else $error("call did not load pc");
   a_call_push: assert property (@(posedge ref_clk) disable iff (!nrst)
      exec_now && op == core_exec_pkg::OP_ISC |=>
      stack_head_push.en && stack_head_push.ret_addr == $past(pc_reg) + 15'h0001)
      else $error("call push wrong");
   sequence s_flow;
      exec_now && (is_jump || op == core_exec_pkg::OP_ISC);
   endsequence
   a_flow_two_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_flow |=> busy ##1 !busy)
      else $error("jump not two cycles");
   a_jump_target: assert property (@(posedge ref_clk) disable iff (!nrst)
      exec_now && is_jump |=>
      pc_reg == {$past(program_counter_upper_latch[6:3]), $past(instr[10:0])})
      else $error("jump target wrong");
   a_flag_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
      exec_now && (is_jump || op == core_exec_pkg::OP_ISC ||
      op == core_exec_pkg::OP_DSZ) |=> $stable(zero_flag_reg))
      else $error("zero flag changed");
   a_skip_flush: assert property (@(posedge ref_clk) disable iff (!nrst)
      take_skip |=> busy ##1 !busy && !retire)
      else $error("skip did not flush");
   a_zero_set: assert property (@(posedge ref_clk) disable iff (!nrst)
      exec_now && (op == core_exec_pkg::OP_ZREG || op == core_exec_pkg::OP_ZACC)
      |=> zero_flag_reg)
      else $error("zero flag not set");
   a_zero_result: assert property (@(posedge ref_clk) disable iff (!nrst)
      exec_now && (op == core_exec_pkg::OP_COMP || op == core_exec_pkg::OP_DEC)
      |=> zero_flag_reg == ($past(result) == `ZERO_BYTE))
      else $error("zero flag mismatch");
   a_wdk_effects: assert property (@(posedge ref_clk) disable iff (!nrst)
      exec_now && op == core_exec_pkg::OP_WDK |=> watchdog_counter_clr &&
      watchdog_prescaler_clr && watchdog_expiry_flag_n && sleep_entry_flag_n)
      else $error("watchdog kick incomplete");
endmodule // core_instruction_subset_exec

// ### rtl/op_decode.sv
// instruction word classifier for the execution block
// purely combinational, word assumed stable while valid
`timescale 1ns/1ps
`include "core_exec_map.svh"
module op_decode (
   // instruction
   input  wire logic [13:0]        instr,
   // classification
   output core_exec_pkg::op_t       op,
   output logic                     is_jump
);
   always_comb begin
      op      = core_exec_pkg::OP_NONE;
      is_jump = (instr[13:11] == `OP3_JUMP);
      if (instr == `OP_ISC) begin
         op = core_exec_pkg::OP_ISC;
      end else if (instr == `OP_ZACC) begin
         op = core_exec_pkg::OP_ZACC;
      end else if (instr == `OP_WDK) begin
         op = core_exec_pkg::OP_WDK;
      end else if (instr[13:8] == `OP6_COMP) begin
         op = core_exec_pkg::OP_COMP;
      end else if (instr[13:8] == `OP6_DEC) begin
         op = core_exec_pkg::OP_DEC;
      end else if (instr[13:8] == `OP6_DSZ) begin
         op = core_exec_pkg::OP_DSZ;
      end else if (instr[13:7] == `OP7_ZREG) begin
         op = core_exec_pkg::OP_ZREG;
      end
   end
endmodule // op_decode

// ### shared/core_exec_map.svh
// constants for the instruction subset execution block
// assumes 14-bit instruction words with the usual field layout
`ifndef CORE_EXEC_MAP_SVH
`define CORE_EXEC_MAP_SVH
`define PC_RESET        15'h0000
`define ACC_RESET       8'h00
`define ZERO_FLAG_RESET 1'b0
`define STATUS_N_RESET  1'b1
`define ZERO_BYTE       8'h00
`define ONE_BYTE        8'h01
`define DEST_BIT        7
`define JUMP_CYCLES     2'h2
`define ONE_CYCLE       2'h1
// opcode patterns: whole 14-bit words, then 6-, 7- and 3-bit upper-field prefixes
`define OP_ISC          14'h000a
`define OP_ZACC         14'h0103
`define OP_WDK          14'h0064
`define OP6_COMP        6'h09
`define OP6_DEC         6'h03
`define OP6_DSZ         6'h0b
`define OP7_ZREG        7'h03
`define OP3_JUMP        3'h5
`endif

// ### shared/core_exec_pkg.sv
// types for the instruction subset execution block
// used together with core_exec_map.svh
package core_exec_pkg;
   typedef enum logic [7:0] {
      OP_NONE  = 8'h01,
      OP_ISC   = 8'h02,
      OP_COMP  = 8'h04,
      OP_ZREG  = 8'h08,
      OP_DEC   = 8'h10,
      OP_ZACC  = 8'h20,
      OP_DSZ   = 8'h40,
      OP_WDK   = 8'h80
   } op_t;
   typedef enum logic [2:0] {
      ST_EXEC  = 3'h1,
      ST_FLUSH = 3'h2,
      ST_SETTLE = 3'h4
   } state_t;
   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } file_wr_t;
   typedef struct packed {
      logic        en;
      logic [14:0] ret_addr;
   } push_t;
endpackage
